// *** bench/wdgc_top_bench.sv ***
`timescale 1ns/1ps
module wdgc_top_bench import wdgc_pkg::*;;
    // ==========================================================
    // Stimulus and observed signals
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata_ff;
    logic avs_waitrequest_ff;
    logic hw_activation_option = 1'b0;
    logic external_stop_control_option = 1'b0;
    logic nmi_pin = 1'b0;
    logic stop_exec = 1'b0;
    logic wait_exec = 1'b0;
    logic wake_irq = 1'b0;
    wdgc_pwr_e pwr_state_ff;
    logic mcu_reset_n_ff;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    int ph = 0;
    logic rst_seen = 1'b0;
    logic [31:0] exp_q[$];

    always #10 sys_clk = ~sys_clk;

    wdgc_top u_dut (
        .sys_clk(sys_clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata_ff(avs_readdata_ff), .avs_waitrequest_ff(avs_waitrequest_ff),
        .hw_activation_option(hw_activation_option),
        .external_stop_control_option(external_stop_control_option),
        .nmi_pin(nmi_pin), .stop_exec(stop_exec), .wait_exec(wait_exec),
        .wake_irq(wake_irq), .pwr_state_ff(pwr_state_ff),
        .mcu_reset_n_ff(mcu_reset_n_ff)
    );

    // ==========================================================
    // Reporting
    task finish_test();
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Register image: count LSB lands in bit 7
    function automatic logic [7:0] enc(input logic [6:0] c, input logic a);
        return {c[0], c[1], c[2], c[3], c[4], c[5], c[6], a};
    endfunction

    // ==========================================================
    // Monitor, timeout and tick phase
    // Phase mirrors the decrement divider so reads avoid a tick edge
    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest_ff === 1'b0 && exp_q.size() > 0) begin
            check(avs_readdata_ff, exp_q.pop_front());
        end
        if (mcu_reset_n_ff === 1'b0) begin
            rst_seen = 1'b1;
        end
        if (!nrst) begin
            ph = 0;
        end else if (pwr_state_ff !== WDGC_PWR_STOP) begin
            ph = (ph == 3071) ? 0 : ph + 1;
        end
        cyc++;
        if (cyc == 80000) begin
            errors++;
            finish_test();
        end
    end

    // ==========================================================
    // Drivers
    task idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task do_reset();
        @(posedge sys_clk);
        nrst <= 1'b0;
        idle(10);
        nrst <= 1'b1;
        idle(3);
    endtask

    task sync();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ph != 200 && n < 4000);
    endtask

    // Waits for the slave as long as it takes; the cycle ceiling ends a hang
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic be);
        @(posedge sys_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= {3'h0, be};
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest_ff !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b1);
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 8'h00, 1'b1);
    endtask

    // 0 stop, 1 wait, other wake; state is settled on return
    task pulse(input int which);
        @(posedge sys_clk);
        case (which)
            0: stop_exec <= 1'b1;
            1: wait_exec <= 1'b1;
            default: wake_irq <= 1'b1;
        endcase
        @(posedge sys_clk);
        stop_exec <= 1'b0;
        wait_exec <= 1'b0;
        wake_irq <= 1'b0;
        @(posedge sys_clk);
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        logic [6:0] c;
        int n;
        int k;
        void'($urandom(32'h3df5));
        do_reset();
        rd(8'hd8, 8'hfe);
        wr(8'hd0, 8'h00);
        rd(8'hd0, 8'h00);
        rd(8'hd8, 8'hfe);
        sync();
        repeat (4) begin
            c = {1'b1, 6'($urandom_range(63, 2))};
            wr(8'hd8, enc(c, 1'b0));
            rd(8'hd8, enc(c, 1'b0));
        end
        idle(6144);
        rd(8'hd8, enc(c - 7'd2, 1'b0));
        rd(8'hd8, enc(c - 7'd2, 1'b0));
        // Inactive timer wraps through zero without a reset
        sync();
        rst_seen = 1'b0;
        wr(8'hd8, enc(7'h01, 1'b0));
        idle(6144);
        rd(8'hd8, 8'hfe);
        check({31'h0, rst_seen}, 32'h0);
        sync();
        wr(8'hd8, enc(7'h50, 1'b0));
        pulse(1);
        check(pwr_state_ff, WDGC_PWR_WAIT);
        idle(3072);
        pulse(2);
        check(pwr_state_ff, WDGC_PWR_RUN);
        rd(8'hd8, enc(7'h4f, 1'b0));
        sync();
        wr(8'hd8, enc(7'h50, 1'b0));
        pulse(0);
        check(pwr_state_ff, WDGC_PWR_STOP);
        idle(4000);
        pulse(2);
        check(pwr_state_ff, WDGC_PWR_RUN);
        rd(8'hd8, enc(7'h50, 1'b0));
        idle(3072);
        rd(8'hd8, enc(7'h4f, 1'b0));
        // Software activation and stop handling
        sync();
        wr(8'hd8, enc(7'h60, 1'b1));
        rd(8'hd8, enc(7'h60, 1'b1));
        wr(8'hd8, enc(7'h60, 1'b0));
        rd(8'hd8, enc(7'h60, 1'b1));
        pulse(0);
        check(pwr_state_ff, WDGC_PWR_WAIT);
        pulse(2);
        external_stop_control_option <= 1'b1;
        idle(4);
        pulse(0);
        check(pwr_state_ff, WDGC_PWR_WAIT);
        pulse(2);
        nmi_pin <= 1'b1;
        idle(4);
        pulse(0);
        check(pwr_state_ff, WDGC_PWR_STOP);
        pulse(2);
        check(pwr_state_ff, WDGC_PWR_RUN);
        rst_seen = 1'b0;
        wr(8'hd8, 8'hfd);
        n = 0;
        while (mcu_reset_n_ff !== 1'b0 && n < 6) begin
            @(posedge sys_clk);
            n++;
        end
        k = 0;
        while (mcu_reset_n_ff === 1'b0 && k < 100) begin
            @(posedge sys_clk);
            k++;
        end
        check({31'h0, rst_seen}, 32'h1);
        check(k, 25);
        rd(8'hd8, 8'hfe);
        external_stop_control_option <= 1'b0;
        nmi_pin <= 1'b0;
        do_reset();
        // Hardware option: activation stuck high
        hw_activation_option <= 1'b1;
        idle(4);
        sync();
        wr(8'hd8, enc(7'h55, 1'b0));
        rd(8'hd8, enc(7'h55, 1'b1));
        bus(1'b1, 8'hd8, 8'h02, 1'b0);
        rd(8'hd8, enc(7'h55, 1'b1));
        pulse(0);
        check(pwr_state_ff, WDGC_PWR_WAIT);
        pulse(2);
        // Left alone, the forced watchdog expires within one tick period
        rst_seen = 1'b0;
        wr(8'hd8, enc(7'h40, 1'b0));
        idle(3100);
        check({31'h0, rst_seen}, 32'h1);
        rd(8'hd8, 8'hff);
        finish_test();
    end
endmodule

// *** hdl/wdgc_pkg.sv ***
package wdgc_pkg;
    // ==========================================================
    // Register map and field layout
    localparam logic [7:0] WDGC_REG_ADDR = 8'hd8;
    localparam logic [7:0] WDGC_REG_RESET = 8'hfe;
    localparam int WDGC_CNT_LSB_POS = 7;
    localparam int WDGC_CNT_MSB_POS = 2;
    localparam int WDGC_SR_POS = 1;
    localparam int WDGC_ACT_POS = 0;
    localparam logic [6:0] WDGC_CNT_RESET = 7'h7f;
    localparam logic [6:0] WDGC_CNT_STEP = 7'h01;

    // ==========================================================
    // Timing
    localparam int WDGC_TICK_US = 384;
    localparam int WDGC_REF_OSC_MHZ = 8;
    // Decrement period expressed in oscillator cycles
    localparam int WDGC_TICK_CYCLES = WDGC_TICK_US * WDGC_REF_OSC_MHZ;
    localparam int WDGC_TICK_W = $clog2(WDGC_TICK_CYCLES);
    localparam int WDGC_CLK_PERIOD_NS = 20;
    localparam int WDGC_RST_PULSE_NS = 500;
    localparam int WDGC_RST_CYCLES = WDGC_RST_PULSE_NS / WDGC_CLK_PERIOD_NS;
    localparam int WDGC_RST_W = $clog2(WDGC_RST_CYCLES + 1);

    // ==========================================================
    // Types
    typedef struct packed {
        logic [5:0] t;
        logic sr;
        logic act;
    } wdgc_fields_s;

    typedef enum logic [1:0] {
        WDGC_PWR_RUN = 2'b00,
        WDGC_PWR_WAIT = 2'b01,
        WDGC_PWR_STOP = 2'b11
    } wdgc_pwr_e;

    // ==========================================================
    // Bit-order helpers
    function automatic logic [5:0] wdgc_rev6(input logic [5:0] v);
        logic [5:0] r;
        r = '0;
        for (int i = 0; i < 6; i++) begin
            r[i] = v[5 - i];
        end
        return r;
    endfunction

    function automatic logic [7:0] wdgc_to_reg(input logic [6:0] cnt, input logic act);
        wdgc_fields_s f;
        f.t = wdgc_rev6(cnt[5:0]);
        f.sr = cnt[6];
        f.act = act;
        return f;
    endfunction

    function automatic logic [6:0] wdgc_from_reg(input logic [7:0] v);
        wdgc_fields_s f;
        f = v;
        return {f.sr, wdgc_rev6(f.t)};
    endfunction
endpackage

// *** hdl/wdgc_rst_pulse.sv ***
`timescale 1ns/1ps
module wdgc_rst_pulse
    import wdgc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Trigger and pulse
    input wire logic start,
    output logic rst_pin_n_ff,
    output logic busy
);
    localparam logic [WDGC_RST_W-1:0] LEN = WDGC_RST_W'(WDGC_RST_CYCLES);
    localparam logic [WDGC_RST_W-1:0] ONE = WDGC_RST_W'(1);

    logic [WDGC_RST_W-1:0] left_ff;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            left_ff <= '0;
        end else if (start && left_ff == '0) begin
            left_ff <= LEN;
        end else if (left_ff != '0) begin
            left_ff <= left_ff - ONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rst_pin_n_ff <= 1'b1;
        end else begin
            rst_pin_n_ff <= !((start && left_ff == '0) || left_ff > ONE);
        end
    end

    assign busy = (left_ff != '0);
endmodule

// *** hdl/wdgc_tick_div.sv ***
`timescale 1ns/1ps
module wdgc_tick_div
    import wdgc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Control
    input wire logic en,
    output logic tick
);
    localparam logic [WDGC_TICK_W-1:0] MAX_CNT = WDGC_TICK_W'(WDGC_TICK_CYCLES - 1);
    localparam logic [WDGC_TICK_W-1:0] ONE = WDGC_TICK_W'(1);

    logic [WDGC_TICK_W-1:0] cnt_ff;

    // Holding the count while disabled keeps the frozen phase
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnt_ff <= '0;
        end else if (en) begin
            cnt_ff <= (cnt_ff == MAX_CNT) ? '0 : cnt_ff + ONE;
        end
    end

    assign tick = en && (cnt_ff == MAX_CNT);
endmodule

// *** hdl/wdgc_top.sv ***
// ==========================================================
// Behaviour
// [R1] Six count bits sit in bits 7:2 reversed; bit 7 is count LSB.
// [R2] Register resets to FE hex and lives at address D8 hex.
// [R3] Active watchdog: writing soft-reset bit zero causes an MCU reset.
// [R4] Inactive: soft-reset bit is MSB of a 7-bit down-timer, no reset.
// [R5] Hardware option forces activation bit high; writes cannot clear it.
// [R6] Software option: setting activation starts it; clearing ignored until reset.
// [R7] WAIT leaves watchdog counting unchanged.
// [R8] Inactive watchdog: STOP instruction enters STOP normally.
// [R9] Active, no external stop control: STOP behaves as WAIT.
// [R10] Active with external control: NMI low gives WAIT, high freezes and stops.
// [R11] Wake from STOP resumes decrementing from the frozen value.
// [R12] Decrement every 384 us with an 8 MHz oscillator.
// [R13] Timer users should read twice and accept matching values.
// [R14] Software option: test activation at start-up, write FD to reset.
// [R15] With external control, hold NMI high idle, low when protection needed.
// [R16] Seven-bit count decrements once every 3072 oscillator cycles.
// [R17] Active and soft-reset bit zero: reset pin low about 500 ns.
// [R18] Software refreshes with 02 to FE hex, soft-reset bit set.
// [R19] Writes load the count at once; reads return the live count.
`timescale 1ns/1ps
module wdgc_top
    import wdgc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata_ff,
    output logic avs_waitrequest_ff,
    // Option straps and pins
    input wire logic hw_activation_option,
    input wire logic external_stop_control_option,
    input wire logic nmi_pin,
    // CPU power control
    input wire logic stop_exec,
    input wire logic wait_exec,
    input wire logic wake_irq,
    output wdgc_pwr_e pwr_state_ff,
    // Reset output
    output logic mcu_reset_n_ff
);
    // ==========================================================
    // Pin synchronisers
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic hw_on;
    logic ext_on;
    logic nmi_hi;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= {hw_activation_option, external_stop_control_option, nmi_pin};
            sync2_ff <= sync1_ff;
        end
    end

    assign hw_on = sync2_ff[2];
    assign ext_on = sync2_ff[1];
    assign nmi_hi = sync2_ff[0];

    // ==========================================================
    // Bus decode
    logic hit;
    logic req;
    logic accept;
    logic wr_hit;
    logic [6:0] count_ff;
    logic act_ff;
    logic act_eff;
    logic fire;
    logic pulse_busy;
    logic tick;
    logic div_en;

    assign hit = (avs_address == WDGC_REG_ADDR);
    assign req = avs_read || avs_write;
    assign accept = req && avs_waitrequest_ff;
    // Write lands on the edge that sees waitrequest low
    assign wr_hit = avs_write && !avs_waitrequest_ff && hit && avs_byteenable[0];

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            avs_waitrequest_ff <= 1'b1;
        end else begin
            avs_waitrequest_ff <= !accept;
        end
    end

    // Unmapped reads answer zero; unmapped writes are dropped
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            avs_readdata_ff <= 32'h0;
        end else if (accept && avs_read) begin
            avs_readdata_ff <= hit ? {24'h0, wdgc_to_reg(count_ff, act_eff)} : 32'h0; // [R1] [R19]
        end
    end

    // ==========================================================
    // Activation
    assign act_eff = act_ff || hw_on; // [R5]

    // Sticky once set; only nrst or a watchdog fire clears it
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            act_ff <= 1'b0;
        end else if (fire) begin
            act_ff <= 1'b0;
        end else if (wr_hit && avs_writedata[WDGC_ACT_POS]) begin
            act_ff <= 1'b1; // [R6]
        end
    end

    // ==========================================================
    // Counter
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            count_ff <= WDGC_CNT_RESET; // [R2]
        end else if (fire) begin
            count_ff <= WDGC_CNT_RESET;
        end else if (wr_hit) begin
            count_ff <= wdgc_from_reg(avs_writedata[7:0]); // [R19] [R1]
        end else if (tick) begin
            count_ff <= count_ff - WDGC_CNT_STEP; // [R16] [R4] [R12]
        end
    end

    // Divider halts only in true STOP; WAIT keeps it running
    assign div_en = (pwr_state_ff != WDGC_PWR_STOP); // [R7] [R11]

    wdgc_tick_div u_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .en(div_en),
        .tick(tick)
    );

    // ==========================================================
    // Reset generation
    // A cleared soft-reset bit, by timeout or by write, fires once
    assign fire = act_eff && !count_ff[6] && !pulse_busy; // [R3] [R17] [R4]

    wdgc_rst_pulse u_pulse (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(fire),
        .rst_pin_n_ff(mcu_reset_n_ff),
        .busy(pulse_busy)
    );

    // ==========================================================
    // Low power control
    wdgc_pwr_e nxt_pwr_state;

    always_comb begin
        nxt_pwr_state = pwr_state_ff;
        unique case (pwr_state_ff)
            WDGC_PWR_RUN: begin
                if (stop_exec) begin
                    if (!act_eff) begin
                        nxt_pwr_state = WDGC_PWR_STOP; // [R8]
                    end else if (!ext_on) begin
                        nxt_pwr_state = WDGC_PWR_WAIT; // [R9]
                    end else if (nmi_hi) begin
                        nxt_pwr_state = WDGC_PWR_STOP; // [R10]
                    end else begin
                        nxt_pwr_state = WDGC_PWR_WAIT; // [R10]
                    end
                end else if (wait_exec) begin
                    nxt_pwr_state = WDGC_PWR_WAIT; // [R7]
                end
            end
            WDGC_PWR_WAIT, WDGC_PWR_STOP: begin
                if (wake_irq) begin
                    nxt_pwr_state = WDGC_PWR_RUN; // [R11]
                end
            end
            default: begin
                nxt_pwr_state = WDGC_PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pwr_state_ff <= WDGC_PWR_RUN;
        end else if (fire) begin
            pwr_state_ff <= WDGC_PWR_RUN;
        end else begin
            pwr_state_ff <= nxt_pwr_state;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    logic [WDGC_TICK_W-1:0] gap_ff;
    logic [WDGC_RST_W:0] low_len_ff;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            gap_ff <= '0;
        end else if (tick) begin
            gap_ff <= '0;
        end else if (div_en) begin
            gap_ff <= gap_ff + WDGC_TICK_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            low_len_ff <= '0;
        end else if (!mcu_reset_n_ff) begin
            low_len_ff <= low_len_ff + (WDGC_RST_W + 1)'(1);
        end else begin
            low_len_ff <= '0;
        end
    end

    property p_reg_reset;
        $rose(nrst) |-> count_ff == WDGC_CNT_RESET && !act_ff;
    endproperty
    a_reg_reset: assert property (p_reg_reset) // [R2]
        else $error("register not at reset pattern");

    property p_read_order;
        accept && avs_read && hit |=>
            avs_readdata_ff[7] == $past(count_ff[0]) &&
            avs_readdata_ff[2] == $past(count_ff[5]) &&
            avs_readdata_ff[1] == $past(count_ff[6]);
    endproperty
    a_read_order: assert property (p_read_order) // [R1]
        else $error("read count bits not reversed");

    property p_write_load;
        wr_hit && !fire |=> count_ff == wdgc_from_reg($past(avs_writedata[7:0]));
    endproperty
    a_write_load: assert property (p_write_load) // [R19]
        else $error("write did not load count");

    property p_sw_reset;
        wr_hit && act_eff && !avs_writedata[WDGC_SR_POS] && !pulse_busy
            |-> ##[1:3] !mcu_reset_n_ff;
    endproperty
    a_sw_reset: assert property (p_sw_reset) // [R3]
        else $error("soft reset write gave no reset");

    property p_pulse_len;
        $rose(mcu_reset_n_ff) |-> low_len_ff == (WDGC_RST_W + 1)'(WDGC_RST_CYCLES);
    endproperty
    a_pulse_len: assert property (p_pulse_len) // [R17]
        else $error("reset pulse length wrong");

    property p_no_reset_inactive;
        !act_eff && !pulse_busy && mcu_reset_n_ff
            |=> mcu_reset_n_ff;
    endproperty
    a_no_reset_inactive: assert property (p_no_reset_inactive) // [R4]
        else $error("reset while watchdog inactive");

    property p_hw_act_reads;
        hw_on && accept && avs_read && hit |=> avs_readdata_ff[WDGC_ACT_POS];
    endproperty
    a_hw_act_reads: assert property (p_hw_act_reads) // [R5]
        else $error("forced activation bit reads low");

    property p_act_sticky;
        act_ff && !fire |=> act_ff;
    endproperty
    a_act_sticky: assert property (p_act_sticky) // [R6]
        else $error("activation bit cleared");

    property p_tick_period;
        tick |-> gap_ff == WDGC_TICK_W'(WDGC_TICK_CYCLES - 1);
    endproperty
    a_tick_period: assert property (p_tick_period) // [R16]
        else $error("decrement period wrong");

    property p_stop_inactive;
        pwr_state_ff == WDGC_PWR_RUN && stop_exec && !act_eff && !fire
            |=> pwr_state_ff == WDGC_PWR_STOP;
    endproperty
    a_stop_inactive: assert property (p_stop_inactive) // [R8]
        else $error("inactive stop not entered");

    property p_stop_as_wait;
        pwr_state_ff == WDGC_PWR_RUN && stop_exec && act_eff && !fire &&
            (!ext_on || !nmi_hi) |=> pwr_state_ff == WDGC_PWR_WAIT;
    endproperty
    a_stop_as_wait: assert property (p_stop_as_wait) // [R9]
        else $error("stop not turned into wait");

    property p_stop_ext;
        pwr_state_ff == WDGC_PWR_RUN && stop_exec && act_eff && !fire &&
            ext_on && nmi_hi |=> pwr_state_ff == WDGC_PWR_STOP;
    endproperty
    a_stop_ext: assert property (p_stop_ext) // [R10]
        else $error("external stop not entered");

    property p_frozen;
        pwr_state_ff == WDGC_PWR_STOP && !wr_hit && !fire |=> $stable(count_ff);
    endproperty
    a_frozen: assert property (p_frozen) // [R11]
        else $error("count moved in stop");

    property p_wait_counts;
        pwr_state_ff == WDGC_PWR_WAIT |-> div_en;
    endproperty
    a_wait_counts: assert property (p_wait_counts) // [R7]
        else $error("divider halted in wait");

    property p_timer_wrap;
        !act_eff && tick && count_ff == 7'h00 && !wr_hit |=> count_ff == WDGC_CNT_RESET;
    endproperty
    a_timer_wrap: assert property (p_timer_wrap) // [R4]
        else $error("inactive timer did not wrap");

    property p_wake_run;
        pwr_state_ff != WDGC_PWR_RUN && wake_irq |=> pwr_state_ff == WDGC_PWR_RUN;
    endproperty
    a_wake_run: assert property (p_wake_run) // [R11]
        else $error("wake did not return to run");

    property p_wait_entry;
        pwr_state_ff == WDGC_PWR_RUN && wait_exec && !stop_exec && !fire
            |=> pwr_state_ff == WDGC_PWR_WAIT;
    endproperty
    a_wait_entry: assert property (p_wait_entry) // [R7]
        else $error("wait not entered");

    c_timer_wrap: cover property (!act_eff && tick && count_ff == 7'h00);

    c_timeout: cover property (act_eff && tick && count_ff == 7'h40 ##[1:3] !mcu_reset_n_ff);
    c_stop_entered: cover property (stop_exec ##1 pwr_state_ff == WDGC_PWR_STOP);
    c_stop_wait: cover property (stop_exec && act_eff ##1 pwr_state_ff == WDGC_PWR_WAIT);
    c_read_hit: cover property (accept && avs_read && hit);
endmodule
